// >>> verilog/qlc_pkg.sv
/*
  Package of the quad line channel configuration register bank: register
  offsets, field positions, reset values and clock-format encodings.
  Assumes a host port with a 4-bit register address and 8-bit data.
*/
package qlc_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CH1_CONFIG = 4'h6;
  localparam logic [3:0] ADDR_CH2_CONFIG = 4'h7;
  localparam logic [3:0] ADDR_CH3_CONFIG = 4'h8;
  localparam logic [3:0] ADDR_CH4_CONFIG = 4'h9;
  localparam logic [3:0] ADDR_UPPER_CODE = 4'hb;
  localparam logic [3:0] ADDR_SHARED_CTRL = 4'hc;
  localparam logic [3:0] ADDR_GLOBAL_CTRL4 = 4'h4;
  localparam logic [3:0] ADDR_GLOBAL_CTRL5 = 4'h5;

  // ---------------------------------------------------------------
  // per-channel configuration fields
  // ---------------------------------------------------------------
  localparam int CFG_POWERDOWN = 0;
  localparam int CFG_MASK = 1;
  localparam int CFG_ALL_ONES = 2;
  localparam int CFG_LOOP_HI = 3;
  localparam int CFG_LOOP_LO = 4;
  localparam int CFG_EQ_2 = 5;
  localparam int CFG_EQ_1 = 6;
  localparam int CFG_EQ_0 = 7;

  // ---------------------------------------------------------------
  // line code, shared control and global control fields
  // ---------------------------------------------------------------
  localparam int UPC_ZS_CH4 = 4;
  localparam int UPC_ZS_CH3 = 6;
  localparam logic [7:0] UPC_WRITABLE = 8'h50;
  localparam int SHC_ANALOG_SIGNAL_LOSS_TIMER = 0;
  localparam int SHC_RX_SHUT_ANALOG_SIGNAL_LOSS = 1;
  localparam int SHC_SUPP_DLOSS = 2;
  localparam int SHC_SUPP_TXCLK = 3;
  localparam int SHC_SUPP_DRVMON = 4;
  localparam int SHC_LOW_BW = 5;
  localparam int SHC_ZS_CH2 = 6;
  localparam int SHC_ZS_CH1 = 7;
  localparam int GC4_HIZ_BASE = 4;
  localparam int GC5_DLOSS_SHUT = 7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CH_CONFIG = 8'h00;
  localparam logic [7:0] RST_UPPER_CODE = 8'h00;
  localparam logic [7:0] RST_SHARED_CTRL = 8'h00;
  localparam logic [7:0] RST_GLOBAL_CTRL4 = 8'hf0;
  localparam logic [7:0] RST_GLOBAL_CTRL5 = 8'h00;

  // ---------------------------------------------------------------
  // reference clock formats
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    QLC_REF_16X_DS1,
    QLC_REF_16X_CEPT,
    QLC_REF_1X_DS1,
    QLC_REF_1X_CEPT
  } qlc_ref_fmt_t;
  localparam int REF_16X_DS1_KHZ = 24704;
  localparam int REF_16X_CEPT_KHZ = 32768;
  localparam int REF_1X_DS1_KHZ = 1544;
  localparam int REF_1X_CEPT_KHZ = 2048;
endpackage

// >>> verilog/qlc_ref_select.sv
/*
  Reference-clock format decoder: turns the two strap pins into the format
  the recovery and attenuator logic use. Assumes straps are synchronous and
  are default low when open (pull-downs outside the logic).
*/
`timescale 1ns/1ns
`default_nettype none
module qlc_ref_select (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic ref_rate_select_i,
  input wire logic synth_standard_select_i,
  output var qlc_pkg::qlc_ref_fmt_t fmt_o,
  output logic synth_enable_o
);
  typedef struct packed {
    qlc_pkg::qlc_ref_fmt_t fmt;
    logic synth_en;
  } qlc_ref_state_t;

  qlc_ref_state_t st;
  qlc_ref_state_t next_st;

  // ---------------------------------------------------------------
  // format decode
  // ---------------------------------------------------------------
  // strap levels are caught by the clock, never by the reset itself
  always_comb begin
    next_st = st;
    if (rst_i) begin
      next_st.fmt = qlc_pkg::QLC_REF_16X_DS1;
      next_st.synth_en = 1'b0;
    end else if (ce_i) begin
      if (!ref_rate_select_i) begin
        next_st.fmt = qlc_pkg::QLC_REF_16X_DS1;
        next_st.synth_en = 1'b0;
      end else begin
        // line-rate reference: synthesizer multiplies up
        next_st.synth_en = 1'b1;
        next_st.fmt = synth_standard_select_i ? qlc_pkg::QLC_REF_1X_CEPT : qlc_pkg::QLC_REF_1X_DS1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    st <= next_st;
  end

  assign fmt_o = st.fmt;
  assign synth_enable_o = st.synth_en;

  // standard pin ignored in 16x mode
  property p_std_ignored;
    @(posedge core_clk_i) disable iff (rst_i)
      (ce_i && !ref_rate_select_i) |=> (fmt_o == qlc_pkg::QLC_REF_16X_DS1 && !synth_enable_o);
  endproperty
  a_std_ignored: assert property (p_std_ignored) else $error("standard pin acted in 16x mode");

  property p_line_rate;
    @(posedge core_clk_i) disable iff (rst_i)
      (ce_i && ref_rate_select_i) |=> (synth_enable_o &&
        (fmt_o == ($past(synth_standard_select_i) ? qlc_pkg::QLC_REF_1X_CEPT : qlc_pkg::QLC_REF_1X_DS1)));
  endproperty
  a_line_rate: assert property (p_line_rate) else $error("line-rate format wrong");
endmodule // qlc_ref_select
`default_nettype wire

// >>> verilog/qlc_config_regs.sv
/*
  Configuration register bank for a four-channel line interface: four
  per-channel registers, a line-code register for channels 3-4, a shared
  alarm/code control register and the two global control registers that the
  channel controls depend on. Assumes a synchronous host port (chip select,
  write strobe, 4-bit address, 8-bit data) and synchronous strap inputs.
*/
`timescale 1ns/1ns
`default_nettype none
module qlc_config_regs #(
  parameter int CHANNELS = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // host register port
  input wire logic cs_i,
  input wire logic wr_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // clock format straps
  input wire logic ref_rate_select_i,
  input wire logic synth_standard_select_i,
  // channel alarm events and loopback status from the line side
  input wire logic [CHANNELS-1:0] analog_signal_loss_i,
  input wire logic [CHANNELS-1:0] digital_signal_loss_i,
  input wire logic [CHANNELS-1:0] tx_clock_loss_i,
  input wire logic [CHANNELS-1:0] drvmon_alarm_i,
  input wire logic [CHANNELS-1:0] full_local_loopback_i,
  input wire logic [CHANNELS-1:0] remote_loop_switching_i,
  // per-channel controls
  output logic [CHANNELS-1:0] channel_powerdown_o,
  output logic [CHANNELS-1:0] send_all_ones_o,
  output logic [2*CHANNELS-1:0] loop_mode_o,
  output logic [3*CHANNELS-1:0] equalizer_sel_o,
  output logic [CHANNELS-1:0] zero_subst_o,
  output logic [CHANNELS-1:0] driver_hiz_o,
  output logic [CHANNELS-1:0] alarm_irq_req_o,
  output logic [CHANNELS-1:0] rx_shutdown_o,
  // shared controls
  output logic analog_loss_timer_sel_o,
  output logic low_bw_jitter_option_o,
  output logic [1:0] ref_fmt_o,
  output logic synth_enable_o
);
  typedef struct packed {
    logic [CHANNELS-1:0][7:0] ch_cfg;
    logic [7:0] upper_code;
    logic [7:0] shared_ctrl;
    logic [7:0] gctrl4;
    logic [7:0] gctrl5;
    logic [7:0] rdata;
    logic [CHANNELS-1:0] channel_powerdown;
    logic [CHANNELS-1:0] all_ones;
    logic [2*CHANNELS-1:0] loop_mode;
    logic [3*CHANNELS-1:0] eq_sel;
    logic [CHANNELS-1:0] zs;
    logic [CHANNELS-1:0] hiz;
    logic [CHANNELS-1:0] irq;
    logic [CHANNELS-1:0] rx_shut;
    logic analog_signal_loss_timer;
    logic low_bw;
  } qlc_regs_state_t;

  qlc_regs_state_t st;
  qlc_regs_state_t next_st;
  qlc_pkg::qlc_ref_fmt_t ref_fmt;
  logic synth_en;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // channel index of a per-channel register address, or CHANNELS if none
  function automatic int ch_of(input logic [3:0] a);
    int n;
    n = CHANNELS;
    if (a >= qlc_pkg::ADDR_CH1_CONFIG && a <= qlc_pkg::ADDR_CH4_CONFIG) begin
      n = int'(a - qlc_pkg::ADDR_CH1_CONFIG);
    end
    return n;
  endfunction

  // ---------------------------------------------------------------
  // reference clock format
  // ---------------------------------------------------------------
  qlc_ref_select u_ref_select (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .ref_rate_select_i(ref_rate_select_i),
    .synth_standard_select_i(synth_standard_select_i),
    .fmt_o(ref_fmt),
    .synth_enable_o(synth_en)
  );

  // ---------------------------------------------------------------
  // register writes, readback and derived controls
  // ---------------------------------------------------------------
  // derived controls are registered from the register state, so a write
  // shows at the outputs two edges later; the host is slow next to this
  always_comb begin
    int c;
    logic alarm;
    c = ch_of(addr_i);
    alarm = 1'b0;
    next_st = st;
    if (rst_i) begin
      for (int i = 0; i < CHANNELS; i++) begin
        next_st.ch_cfg[i] = qlc_pkg::RST_CH_CONFIG;
      end
      next_st.upper_code = qlc_pkg::RST_UPPER_CODE;
      next_st.shared_ctrl = qlc_pkg::RST_SHARED_CTRL;
      next_st.gctrl4 = qlc_pkg::RST_GLOBAL_CTRL4;
      next_st.gctrl5 = qlc_pkg::RST_GLOBAL_CTRL5;
      next_st.rdata = 8'h00;
      next_st.channel_powerdown = '0;
      next_st.all_ones = '0;
      next_st.loop_mode = '0;
      next_st.eq_sel = '0;
      next_st.zs = '0;
      next_st.hiz = '1;
      next_st.irq = '0;
      next_st.rx_shut = '0;
      next_st.analog_signal_loss_timer = 1'b0;
      next_st.low_bw = 1'b0;
    end else if (ce_i) begin
      // host write; reserved line-code bits are not stored
      if (cs_i && wr_i) begin
        if (c < CHANNELS) begin
          next_st.ch_cfg[c] = wdata_i;
        end else if (addr_i == qlc_pkg::ADDR_UPPER_CODE) begin
          next_st.upper_code = wdata_i & qlc_pkg::UPC_WRITABLE;
        end else if (addr_i == qlc_pkg::ADDR_SHARED_CTRL) begin
          next_st.shared_ctrl = wdata_i;
        end else if (addr_i == qlc_pkg::ADDR_GLOBAL_CTRL4) begin
          next_st.gctrl4 = wdata_i;
        end else if (addr_i == qlc_pkg::ADDR_GLOBAL_CTRL5) begin
          next_st.gctrl5 = wdata_i;
        end
      end
      // readback; unmapped addresses read zero
      if (c < CHANNELS) begin
        next_st.rdata = st.ch_cfg[c];
      end else if (addr_i == qlc_pkg::ADDR_UPPER_CODE) begin
        next_st.rdata = st.upper_code;
      end else if (addr_i == qlc_pkg::ADDR_SHARED_CTRL) begin
        next_st.rdata = st.shared_ctrl;
      end else if (addr_i == qlc_pkg::ADDR_GLOBAL_CTRL4) begin
        next_st.rdata = st.gctrl4;
      end else if (addr_i == qlc_pkg::ADDR_GLOBAL_CTRL5) begin
        next_st.rdata = st.gctrl5;
      end else begin
        next_st.rdata = 8'h00;
      end
      // per-channel controls
      for (int i = 0; i < CHANNELS; i++) begin
        next_st.channel_powerdown[i] = st.ch_cfg[i][qlc_pkg::CFG_POWERDOWN];
        next_st.all_ones[i] = st.ch_cfg[i][qlc_pkg::CFG_ALL_ONES];
        next_st.loop_mode[2*i +: 2] = {st.ch_cfg[i][qlc_pkg::CFG_LOOP_HI],
                                       st.ch_cfg[i][qlc_pkg::CFG_LOOP_LO]};
        next_st.eq_sel[3*i +: 3] = {st.ch_cfg[i][qlc_pkg::CFG_EQ_2],
                                    st.ch_cfg[i][qlc_pkg::CFG_EQ_1],
                                    st.ch_cfg[i][qlc_pkg::CFG_EQ_0]};
        next_st.hiz[i] = st.gctrl4[qlc_pkg::GC4_HIZ_BASE + i];
        // alarm qualification: suppression options remove alarms
        // caused by the device's own test or idle states
        alarm = analog_signal_loss_i[i] | tx_clock_loss_i[i];
        if (!(st.shared_ctrl[qlc_pkg::SHC_SUPP_DLOSS] && full_local_loopback_i[i])) begin
          alarm = alarm | digital_signal_loss_i[i];
        end
        if (st.shared_ctrl[qlc_pkg::SHC_SUPP_TXCLK] && remote_loop_switching_i[i]) begin
          alarm = analog_signal_loss_i[i] |
                  (digital_signal_loss_i[i] &
                   !(st.shared_ctrl[qlc_pkg::SHC_SUPP_DLOSS] && full_local_loopback_i[i]));
        end
        if (!(st.shared_ctrl[qlc_pkg::SHC_SUPP_DRVMON] && st.hiz[i])) begin
          alarm = alarm | drvmon_alarm_i[i];
        end
        next_st.irq[i] = alarm & !st.ch_cfg[i][qlc_pkg::CFG_MASK];
        // receiver shutdown: digital select, analog select works with it
        next_st.rx_shut[i] = st.gctrl5[qlc_pkg::GC5_DLOSS_SHUT] &
                             (digital_signal_loss_i[i] |
                              (st.shared_ctrl[qlc_pkg::SHC_RX_SHUT_ANALOG_SIGNAL_LOSS] &
                               analog_signal_loss_i[i]));
      end
      next_st.zs[0] = st.shared_ctrl[qlc_pkg::SHC_ZS_CH1];
      next_st.zs[1] = st.shared_ctrl[qlc_pkg::SHC_ZS_CH2];
      next_st.zs[2] = st.upper_code[qlc_pkg::UPC_ZS_CH3];
      next_st.zs[3] = st.upper_code[qlc_pkg::UPC_ZS_CH4];
      next_st.analog_signal_loss_timer = st.shared_ctrl[qlc_pkg::SHC_ANALOG_SIGNAL_LOSS_TIMER];
      // low-bandwidth option only meaningful in CEPT formats
      next_st.low_bw = st.shared_ctrl[qlc_pkg::SHC_LOW_BW];
    end
  end

  always_ff @(posedge core_clk_i) begin
    st <= next_st;
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register or the format decoder's register
  // ---------------------------------------------------------------
  assign rdata_o = st.rdata;
  assign channel_powerdown_o = st.channel_powerdown;
  assign send_all_ones_o = st.all_ones;
  assign loop_mode_o = st.loop_mode;
  assign equalizer_sel_o = st.eq_sel;
  assign zero_subst_o = st.zs;
  assign driver_hiz_o = st.hiz;
  assign alarm_irq_req_o = st.irq;
  assign rx_shutdown_o = st.rx_shut;
  assign analog_loss_timer_sel_o = st.analog_signal_loss_timer;
  assign low_bw_jitter_option_o = st.low_bw;
  // recovery and attenuator are timed from this format only
  assign ref_fmt_o = ref_fmt;
  assign synth_enable_o = synth_en;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_readback;
    @(posedge core_clk_i) disable iff (rst_i)
      (ce_i && cs_i && wr_i && addr_i == qlc_pkg::ADDR_SHARED_CTRL) ##1 (ce_i && !(cs_i && wr_i)) ##1
      (ce_i && !(cs_i && wr_i) && addr_i == qlc_pkg::ADDR_SHARED_CTRL) |=> (rdata_o == $past(wdata_i, 3));
  endproperty
  a_readback: assert property (p_readback) else $error("readback differs from write");

  property p_powerdown;
    @(posedge core_clk_i) disable iff (rst_i)
      (ce_i && cs_i && wr_i && addr_i == qlc_pkg::ADDR_CH1_CONFIG) ##1 ce_i |=>
      (channel_powerdown_o[0] == $past(wdata_i[qlc_pkg::CFG_POWERDOWN], 2));
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("powerdown not applied");

  property p_mask;
    @(posedge core_clk_i) disable iff (rst_i)
      (ce_i && st.ch_cfg[0][qlc_pkg::CFG_MASK]) |=> !alarm_irq_req_o[0];
  endproperty
  a_mask: assert property (p_mask) else $error("masked channel raised alarm");

  property p_all_ones;
    @(posedge core_clk_i) disable iff (rst_i)
      ce_i |=> (send_all_ones_o[2] == $past(st.ch_cfg[2][qlc_pkg::CFG_ALL_ONES]));
  endproperty
  a_all_ones: assert property (p_all_ones) else $error("all-ones control wrong");

  property p_zs_ch4;
    @(posedge core_clk_i) disable iff (rst_i)
      ce_i |=> (zero_subst_o[3] == $past(st.upper_code[qlc_pkg::UPC_ZS_CH4]));
  endproperty
  a_zs_ch4: assert property (p_zs_ch4) else $error("channel 4 code enable wrong");

  property p_zs_ch1;
    @(posedge core_clk_i) disable iff (rst_i)
      ce_i |=> (zero_subst_o[0] == $past(st.shared_ctrl[qlc_pkg::SHC_ZS_CH1]));
  endproperty
  a_zs_ch1: assert property (p_zs_ch1) else $error("channel 1 code enable wrong");

  property p_hiz_reset;
    @(posedge core_clk_i) rst_i |=> (driver_hiz_o == '1);
  endproperty
  a_hiz_reset: assert property (p_hiz_reset) else $error("drivers not hiz after reset");

  property p_dloss_suppress;
    @(posedge core_clk_i) disable iff (rst_i)
      (ce_i && st.shared_ctrl[qlc_pkg::SHC_SUPP_DLOSS] && full_local_loopback_i[1] &&
       !analog_signal_loss_i[1] && !tx_clock_loss_i[1] && !drvmon_alarm_i[1]) |=> !alarm_irq_req_o[1];
  endproperty
  a_dloss_suppress: assert property (p_dloss_suppress) else $error("digital loss not suppressed");
endmodule // qlc_config_regs
`default_nettype wire

// >>> testbench/qlc_host_model.sv
/*
  Host processor model: owns the register port of the config bank and
  offers write and read tasks to the bench.
  Assumes one core clock shared with the bank and a bench calling its tasks.
*/
`timescale 1ns/1ns
`default_nettype none
module qlc_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic cs_o,
  output logic wr_o,
  output logic [3:0] addr_o,
  output logic [7:0] wdata_o
);
  // ---------------------------------------------------------------
  // bus idle and release
  // ---------------------------------------------------------------
  // select and write drop; released address and data lines flip instead of holding a stale copy of the last cycle
  initial begin
    cs_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 4'h0;
    wdata_o = 8'h00;
  end
  task automatic release_bus();
    cs_o <= 1'b0;
    wr_o <= 1'b0;
    addr_o <= ~addr_o;
    wdata_o <= ~wdata_o;
  endtask

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  // raw lets a scenario break the reserved-bit habit on purpose
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d, input logic raw);
    @(posedge clk_i);
    cs_o <= 1'b1;
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= (a == qlc_pkg::ADDR_UPPER_CODE && !raw) ? (d & qlc_pkg::UPC_WRITABLE) : d;
    @(posedge clk_i);
    release_bus();
  endtask
  // address held until the data registered at the taking edge is picked up
  // at the next edge, before that edge moves it; only then is the bus freed
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    cs_o <= 1'b1;
    wr_o <= 1'b0;
    addr_o <= a;
    @(posedge clk_i);
    @(posedge clk_i);
    d = rdata_i;
    release_bus();
  endtask
endmodule // qlc_host_model
`default_nettype wire

// >>> testbench/qlc_config_regs_bench.sv
/*
  Self-checking bench of the config register bank: host model on the
  register port, alarm, loopback and strap levels driven here.
  Assumes package and host model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module qlc_config_regs_bench;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic cs, wr;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, v;
  logic rate = 1'b0;
  logic std_sel = 1'b0;
  logic [3:0] aloss = 4'h0, dloss = 4'h0, txl = 4'h0, drv = 4'h0, fll = 4'h0, rsw = 4'h0;
  logic [3:0] pd, ao, zs, hiz, irq, rxs, e_pd, e_ao;
  logic [7:0] lm, e_lm;
  logic [11:0] eq, e_eq;
  logic tsel, lbw, synth;
  logic [1:0] fmt;
  logic [7:0] pat [4] = '{8'h35, 8'hca, 8'h5b, 8'ha4};
  logic [3:0] raddr [8] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'hb, 4'hc, 4'h4, 4'h5};
  int failures = 0;
  int comparisons = 0;

  // 25 MHz core clock, free-running and never gated, like the reference
  always #20 core_clk_i = ~core_clk_i;

  qlc_config_regs #(.CHANNELS(4)) DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .cs_i(cs), .wr_i(wr), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
    .ref_rate_select_i(rate), .synth_standard_select_i(std_sel),
    .analog_signal_loss_i(aloss), .digital_signal_loss_i(dloss), .tx_clock_loss_i(txl),
    .drvmon_alarm_i(drv), .full_local_loopback_i(fll), .remote_loop_switching_i(rsw),
    .channel_powerdown_o(pd), .send_all_ones_o(ao), .loop_mode_o(lm), .equalizer_sel_o(eq),
    .zero_subst_o(zs), .driver_hiz_o(hiz), .alarm_irq_req_o(irq), .rx_shutdown_o(rxs),
    .analog_loss_timer_sel_o(tsel), .low_bw_jitter_option_o(lbw),
    .ref_fmt_o(fmt), .synth_enable_o(synth)
  );
  qlc_host_model host (.clk_i(core_clk_i), .rdata_i(rdata), .cs_o(cs), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));

  // ---------------------------------------------------------------
  // check helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd_reg(a, d);
    chk($sformatf("rdata of %h", a), 16'(exp), 16'(d));
  endtask
  // derived controls follow a write two edges later and an alarm or strap input change one edge later
  task automatic settle();
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    // reset state with open strap pins
    chk("driver_hiz", 16'hf, 16'(hiz));
    chk("ref_fmt", 16'h0, 16'(fmt));
    chk("synth_enable", 16'h0, 16'(synth));
    for (int i = 0; i < 8; i++) rdchk(raddr[i], (i == 6) ? 8'hf0 : 8'h00);
    // every channel field toggled both ways, one pattern per channel
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        v = p ? ~pat[i] : pat[i];
        host.wr_reg(qlc_pkg::ADDR_CH1_CONFIG + 4'(i), v, 1'b0);
        e_pd[i] = v[0];
        e_ao[i] = v[2];
        e_lm[2*i +: 2] = {v[3], v[4]};
        e_eq[3*i +: 3] = {v[5], v[6], v[7]};
      end
      settle();
      chk("channel_powerdown", 16'(e_pd), 16'(pd));
      chk("send_all_ones", 16'(e_ao), 16'(ao));
      chk("loop_mode", 16'(e_lm), 16'(lm));
      chk("equalizer_sel", 16'(e_eq), 16'(eq));
      for (int i = 0; i < 4; i++) rdchk(qlc_pkg::ADDR_CH1_CONFIG + 4'(i), p ? ~pat[i] : pat[i]);
    end
    // line-code reserved bits written as ones, then shared bits
    host.wr_reg(qlc_pkg::ADDR_UPPER_CODE, 8'hff, 1'b1);
    host.wr_reg(qlc_pkg::ADDR_SHARED_CTRL, 8'he1, 1'b0);
    settle();
    chk("zero_subst", 16'hf, 16'(zs));
    chk("analog_loss_timer_sel", 16'h1, 16'(tsel));
    chk("low_bw_jitter_option", 16'h1, 16'(lbw));
    rdchk(qlc_pkg::ADDR_UPPER_CODE, 8'h50);
    rdchk(qlc_pkg::ADDR_SHARED_CTRL, 8'he1);
    host.wr_reg(qlc_pkg::ADDR_UPPER_CODE, 8'h10, 1'b0);
    host.wr_reg(qlc_pkg::ADDR_SHARED_CTRL, 8'h40, 1'b0);
    rdchk(qlc_pkg::ADDR_SHARED_CTRL, 8'h40);
    settle();
    chk("zero_subst", 16'ha, 16'(zs));
    chk("analog_loss_timer_sel", 16'h0, 16'(tsel));
    chk("low_bw_jitter_option", 16'h0, 16'(lbw));
    // unmapped places, then a write while the clock enable is low
    host.wr_reg(4'ha, 8'ha5, 1'b0);
    host.wr_reg(4'hf, 8'ha5, 1'b0);
    rdchk(4'ha, 8'h00);
    rdchk(4'hf, 8'h00);
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    host.wr_reg(qlc_pkg::ADDR_CH1_CONFIG, 8'h00, 1'b0);
    @(posedge core_clk_i);
    ce_i <= 1'b1;
    rdchk(qlc_pkg::ADDR_CH1_CONFIG, ~pat[0]);
    // second reset in mid-run
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    chk("driver_hiz", 16'hf, 16'(hiz));
    rdchk(qlc_pkg::ADDR_CH1_CONFIG, 8'h00);
    // one alarm kind per channel, then suppression and masking
    @(posedge core_clk_i);
    aloss <= 4'h1;
    dloss <= 4'h2;
    txl <= 4'h4;
    drv <= 4'h8;
    fll <= 4'h2;
    rsw <= 4'h4;
    settle();
    chk("alarm_irq_req", 16'hf, 16'(irq));
    host.wr_reg(qlc_pkg::ADDR_SHARED_CTRL, 8'h1c, 1'b0);
    settle();
    chk("alarm_irq_req", 16'h1, 16'(irq));
    @(posedge core_clk_i);
    fll <= 4'h0;
    rsw <= 4'h0;
    host.wr_reg(qlc_pkg::ADDR_GLOBAL_CTRL4, 8'h00, 1'b0);
    settle();
    chk("driver_hiz", 16'h0, 16'(hiz));
    chk("alarm_irq_req", 16'hf, 16'(irq));
    host.wr_reg(qlc_pkg::ADDR_CH1_CONFIG, 8'h02, 1'b0);
    settle();
    chk("alarm_irq_req", 16'he, 16'(irq));
    // receiver shutdown from digital and analog loss
    chk("rx_shutdown", 16'h0, 16'(rxs));
    host.wr_reg(qlc_pkg::ADDR_GLOBAL_CTRL5, 8'h80, 1'b0);
    settle();
    chk("rx_shutdown", 16'h2, 16'(rxs));
    host.wr_reg(qlc_pkg::ADDR_SHARED_CTRL, 8'h02, 1'b0);
    settle();
    chk("rx_shutdown", 16'h3, 16'(rxs));
    // all four strap settings
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk_i);
      rate <= k[1];
      std_sel <= k[0];
      settle();
      chk("ref_fmt", 16'((k > 1) ? k : 0), 16'(fmt));
      chk("synth_enable", 16'(k[1]), 16'(synth));
    end
    summarize();
  end

  // a hang counts as a mismatch; the run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge core_clk_i);
    failures++;
    summarize();
  end
endmodule // qlc_config_regs_bench
`default_nettype wire
